// ==== shared/ddc_pkg.sv ====
// Purpose: constants and types for the dual channel converter control
// Assumes: one system clock; conversion and slow clocks arrive as pins
// Notes: offsets are byte addresses on the plain register port
// Contract
// R1 - global enable bit written one enables, written zero disables
// R2 - soft reset bit returns all registers to reset and disables
// R3 - channel settings apply while enabled, change only while disabled
// R4 - each channel runs only when its own enable bit is one
// R5 - align bit one uses data bits 31:20, zero uses bits 11:0
// R6 - standby run bit keeps a channel working in standby, else halted
// R7 - dither select bit switches the channel dithering mode on or off
// R8 - after enable each channel waits a startup time, then sets ready
// R9 - starts requested while ready is zero are discarded
// R10 - reference field picks internal, analog supply or external; internal at reset
// R11 - new data from bus write or buffer transfer starts a conversion
// R12 - a conversion lasts twenty-four conversion clock periods
// R13 - conversion end sets the channel done flag
// R14 - next start allowed twelve periods after the last; earlier ones wait
// R15 - refresh field times slow clock sets refresh period; zero off, one reserved
// R16 - idle refresh period expiry reconverts the current data value
// R17 - in standby refresh continues only with standby run set
// R18 - a data write during a refresh conversion waits for the next slot
// R19 - differential bit makes both channels convert channel zero data together
// R20 - differential data is two's complement, bit 11 sign, software supplies it
// R21 - in differential mode channel zero settings drive both channels
// R22 - two-bit current field sets output buffer bias per channel
// R23 - control b, event and channel registers ignore writes while enabled
// R24 - start event, resynchronised, copies buffer to data when ready, then converts
// R25 - the refresh counter restarts whenever a conversion starts
package ddc_pkg;
  // register offsets
  localparam logic [7:0] OFS_CTRL_A = 8'h00;
  localparam logic [7:0] OFS_CTRL_B = 8'h04;
  localparam logic [7:0] OFS_EVCTRL = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_CHCTL0 = 8'h10;
  localparam logic [7:0] OFS_CHCTL1 = 8'h14;
  localparam logic [7:0] OFS_DATA0 = 8'h18;
  localparam logic [7:0] OFS_DATA1 = 8'h1c;
  localparam logic [7:0] OFS_BUF0 = 8'h20;
  localparam logic [7:0] OFS_BUF1 = 8'h24;
  // control a / control b field positions
  localparam int SRST_BIT = 0;
  localparam int EN_BIT = 1;
  localparam int DIFFERENTIAL_BIT_BIT = 0;
  localparam int REFERENCE_SELECT_FIELD_LSB = 1;
  // channel control field positions
  localparam int CH_EN_BIT = 0;
  localparam int ALIGN_BIT = 1;
  localparam int DITHER_BIT = 2;
  localparam int STBY_BIT = 3;
  localparam int CUR_LSB = 4;
  localparam int REFR_LSB = 8;
  // status field positions
  localparam int READY_LSB = 0;
  localparam int DONE_LSB = 8;
  // reference select codes and reset values
  localparam logic [1:0] REF_INTERNAL = 2'h0;
  localparam logic [1:0] REF_SUPPLY = 2'h1;
  localparam logic [1:0] REF_EXTERNAL = 2'h2;
  localparam logic [15:0] CFG_RST = 16'h0000;
  // timing in conversion clock periods, then the differential sign flip mask
  localparam logic [4:0] CONV_TICKS = 5'(12 * 2);
  localparam logic [3:0] PIPE_TICKS = 4'hc;
  localparam logic [7:0] STARTUP_TICKS_DEF = 8'h10;
  localparam logic [11:0] SIGN_FLIP = 12'h800;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } ddc_req_t;

  typedef struct packed {
    logic [1:0] on;
    logic [1:0] start;
    logic [1:0] dither;
    logic [1:0] cur0;
    logic [1:0] cur1;
    logic [11:0] code0;
    logic [11:0] code1;
    logic [1:0] reference_select_field;
    logic differential_bit;
  } ddc_core_t;

  typedef struct packed {
    logic [11:0] data;
    logic [11:0] bufv;
    logic ready;
    logic [7:0] up_cnt;
    logic busy;
    logic [4:0] conv_cnt;
    logic [3:0] pipe_cnt;
    logic pend;
    logic pend_buf;
    logic done;
    logic [3:0] ref_cnt;
    logic [11:0] code;
    logic start;
  } ddc_chan_t;

  typedef struct packed {
    logic enable;
    logic differential_bit;
    logic [1:0] reference_select_field;
    logic [1:0] ev_en;
    logic [1:0][15:0] cfg;
    ddc_chan_t [1:0] ch;
    logic [4:0] s1;
    logic [4:0] s2;
    logic [4:0] s3;
    logic [31:0] rdata;
    ddc_core_t core;
  } ddc_state_t;
endpackage

// ==== rtl/ddc_top.sv ====
// Purpose: dual channel converter control: registers, startup, start pacing, refresh
// Assumes: conversion clock, slow clock, start events and standby are asynchronous pins
// Notes: read data stands only in the cycle after the read strobe
//
// The strobed register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
module ddc_top
  import ddc_pkg::*;
#(
  parameter logic [7:0] STARTUP_TICKS = STARTUP_TICKS_DEF
) (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire ddc_req_t REQ,
  output logic [31:0] RDATA,
  input wire logic CONV_CLK,
  input wire logic SLOW_CLK,
  input wire logic [1:0] START_EV,
  input wire logic STANDBY,
  output ddc_core_t CORE
);
  ddc_state_t s;
  ddc_state_t n;
  ddc_chan_t ch;
  logic conv_tick;
  logic slow_tick;
  logic stby;
  logic [1:0] ev_edge;
  logic [15:0] cf;
  logic act;
  logic go;
  logic fin;
  logic [3:0] refr;
  logic cfg_wr_ok;

  // sample picked from a bus word by alignment
  function automatic logic [11:0] pick(input logic [31:0] w, input logic left);
    return left ? w[31:20] : w[11:0];
  endfunction

  // sample placed into a read word by alignment
  function automatic logic [31:0] place(input logic [11:0] d, input logic left);
    return left ? {d, 20'h00000} : {20'h00000, d};
  endfunction

  // edges of the synchronised pins, read from second and third stages only
  assign conv_tick = s.s2[0] & ~s.s3[0];
  assign slow_tick = s.s2[1] & ~s.s3[1];
  assign ev_edge = s.s2[3:2] & ~s.s3[3:2];
  assign stby = s.s2[4];
  assign cfg_wr_ok = REQ.wr & ~s.enable;

  // next state of the whole block
  always_comb begin
    n = s;
    ch = '0;
    cf = '0;
    act = 1'b0;
    go = 1'b0;
    fin = 1'b0;
    refr = '0;
    n.s1 = {STANDBY, START_EV, SLOW_CLK, CONV_CLK};
    n.s2 = s.s1;
    n.s3 = s.s2;
    // global enable follows software
    if (REQ.wr && REQ.addr == OFS_CTRL_A) begin
      n.enable = REQ.wdata[EN_BIT]; // see R1
    end
    // enable-protected registers
    if (cfg_wr_ok) begin // see R23
      unique case (REQ.addr)
        OFS_CTRL_B: begin
          n.differential_bit = REQ.wdata[DIFFERENTIAL_BIT_BIT];
          n.reference_select_field = REQ.wdata[REFERENCE_SELECT_FIELD_LSB +: 2]; // see R10
        end
        OFS_EVCTRL: n.ev_en = REQ.wdata[1:0];
        OFS_CHCTL0: n.cfg[0] = REQ.wdata[15:0]; // see R3
        OFS_CHCTL1: n.cfg[1] = REQ.wdata[15:0];
        default: n.ev_en = s.ev_en;
      endcase
    end
    // per channel sequencing
    for (int i = 0; i < 2; i++) begin
      cf = (s.differential_bit && i == 1) ? s.cfg[0] : s.cfg[i]; // see R21
      ch = s.ch[i];
      ch.start = 1'b0;
      refr = cf[REFR_LSB +: 4];
      act = s.enable & cf[CH_EN_BIT] & ~(stby & ~cf[STBY_BIT]); // see R4 see R6
      // buffer and data writes
      if (REQ.wr && REQ.addr == (i == 0 ? OFS_BUF0 : OFS_BUF1)) begin
        ch.bufv = pick(REQ.wdata, cf[ALIGN_BIT]);
      end
      if (REQ.wr && REQ.addr == (i == 0 ? OFS_DATA0 : OFS_DATA1)) begin
        ch.data = pick(REQ.wdata, cf[ALIGN_BIT]); // see R5
        ch.pend = ch.ready; // see R11 see R9 see R18
      end
      // resynchronised start event asks for a buffer transfer
      if (ev_edge[i] && s.ev_en[i] && ch.ready) begin
        ch.pend_buf = 1'b1; // see R24
      end
      // startup wait after enable
      if (!act) begin
        ch.ready = 1'b0;
        ch.up_cnt = '0;
        ch.pend = 1'b0;
        ch.pend_buf = 1'b0;
        ch.ref_cnt = '0;
      end else if (!ch.ready && conv_tick) begin
        if (ch.up_cnt == STARTUP_TICKS - 8'h01) begin
          ch.ready = 1'b1; // see R8
        end else begin
          ch.up_cnt = ch.up_cnt + 8'h01;
        end
      end
      // refresh timer on the slow clock
      if (act && ch.ready && refr > 4'h1 && slow_tick) begin // see R15 see R17
        if (ch.ref_cnt == refr - 4'h1) begin
          ch.pend = 1'b1; // see R16
        end else begin
          ch.ref_cnt = ch.ref_cnt + 4'h1;
        end
      end
      // pipeline spacing counter
      if (ch.pipe_cnt != 4'h0 && conv_tick) begin
        ch.pipe_cnt = ch.pipe_cnt - 4'h1; // see R14
      end
      fin = ch.busy && conv_tick && ch.conv_cnt == CONV_TICKS - 5'h01;
      if (ch.busy && conv_tick && !fin) begin
        ch.conv_cnt = ch.conv_cnt + 5'h01; // see R12
      end
      // launch when ready and the pipeline slot is free
      go = ch.ready && (ch.pend || ch.pend_buf) && ch.pipe_cnt == 4'h0; // see R14
      if (go) begin
        if (ch.pend_buf) begin
          ch.data = ch.bufv; // see R24
        end
        ch.code = s.differential_bit ? (ch.data ^ SIGN_FLIP) : ch.data; // see R20
        ch.start = 1'b1;
        ch.busy = 1'b1;
        ch.conv_cnt = '0;
        ch.pipe_cnt = PIPE_TICKS;
        ch.pend = 1'b0;
        ch.pend_buf = 1'b0;
        ch.done = 1'b0;
        ch.ref_cnt = '0; // see R25
      end
      // completion sets the flag after any clear
      if (fin) begin
        ch.done = 1'b1; // see R13
        if (!go) begin
          ch.busy = 1'b0;
        end
      end
      n.ch[i] = ch;
      n.core.on[i] = act;
      n.core.dither[i] = cf[DITHER_BIT]; // see R7
      if (i == 0) begin
        n.core.cur0 = cf[CUR_LSB +: 2]; // see R22
      end else begin
        n.core.cur1 = cf[CUR_LSB +: 2];
      end
    end
    // differential: channel one mirrors channel zero with inverted code
    if (s.differential_bit) begin
      n.ch[1] = n.ch[0]; // see R19
      n.ch[1].code = ~n.ch[0].code;
    end
    n.core.start = {n.ch[1].start, n.ch[0].start};
    n.core.code0 = n.ch[0].code;
    n.core.code1 = n.ch[1].code;
    n.core.reference_select_field = s.reference_select_field;
    n.core.differential_bit = s.differential_bit;
    // read data for the cycle after the strobe
    n.rdata = '0;
    if (REQ.rd) begin
      unique case (REQ.addr)
        OFS_CTRL_A: n.rdata = {30'h0, s.enable, 1'b0};
        OFS_CTRL_B: n.rdata = {29'h0, s.reference_select_field, s.differential_bit};
        OFS_EVCTRL: n.rdata = {30'h0, s.ev_en};
        OFS_STATUS: n.rdata = {22'h0, s.ch[1].done, s.ch[0].done, 6'h0,
                               s.ch[1].ready, s.ch[0].ready};
        OFS_CHCTL0: n.rdata = {16'h0, s.cfg[0]};
        OFS_CHCTL1: n.rdata = {16'h0, s.cfg[1]};
        OFS_DATA0: n.rdata = place(s.ch[0].data, s.cfg[0][ALIGN_BIT]);
        OFS_DATA1: n.rdata = place(s.ch[1].data, s.cfg[1][ALIGN_BIT]);
        OFS_BUF0: n.rdata = place(s.ch[0].bufv, s.cfg[0][ALIGN_BIT]);
        OFS_BUF1: n.rdata = place(s.ch[1].bufv, s.cfg[1][ALIGN_BIT]);
        default: n.rdata = '0;
      endcase
    end
    // soft reset returns every register to reset, keeping the synchronisers
    if (REQ.wr && REQ.addr == OFS_CTRL_A && REQ.wdata[SRST_BIT]) begin
      n = '0; // see R2
      n.cfg = {CFG_RST, CFG_RST};
      n.reference_select_field = REF_INTERNAL;
      n.s1 = {STANDBY, START_EV, SLOW_CLK, CONV_CLK};
      n.s2 = s.s1;
      n.s3 = s.s2;
    end
  end

  // state register
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign RDATA = s.rdata;
  assign CORE = s.core;

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RST_N);

  a_enable_follows_write: assert property ( // see R1
    REQ.wr && REQ.addr == OFS_CTRL_A && !REQ.wdata[SRST_BIT]
    |=> s.enable == $past(REQ.wdata[EN_BIT]))
    else $error("enable does not follow control a write");

  a_soft_reset_clears: assert property ( // see R2
    REQ.wr && REQ.addr == OFS_CTRL_A && REQ.wdata[SRST_BIT]
    |=> !s.enable && s.cfg == '0 && !s.differential_bit && s.ev_en == 2'h0)
    else $error("soft reset left state behind");

  a_config_locked: assert property ( // see R23
    s.enable && !(REQ.wr && REQ.addr == OFS_CTRL_A && REQ.wdata[SRST_BIT])
    |=> $stable(s.cfg) && $stable(s.differential_bit) && $stable(s.ev_en))
    else $error("protected register changed while enabled");

  a_start_needs_ready: assert property ( // see R9
    s.ch[0].start |-> $past(s.ch[0].ready))
    else $error("channel zero started while not ready");

  a_start_spacing: assert property ( // see R14
    s.ch[0].start |=> !s.ch[0].start [*8])
    else $error("channel zero restarted inside its pipeline slot");

  a_done_after_busy: assert property ( // see R13
    $rose(s.ch[0].done) |-> $past(s.ch[0].busy) && $past(s.ch[0].conv_cnt) == 5'h17)
    else $error("done flag rose without a finished conversion");

  a_align_left: assert property ( // see R5
    REQ.wr && REQ.addr == OFS_DATA0 && s.cfg[0][ALIGN_BIT] && !s.ch[0].pend_buf && !ev_edge[0]
    |=> s.ch[0].data == $past(REQ.wdata[31:20]))
    else $error("left aligned sample taken from wrong bits");

  a_differential_bit_mirror: assert property ( // see R19
    s.ch[0].start && $past(s.differential_bit)
    |-> s.ch[1].start && s.ch[1].code == ~s.ch[0].code)
    else $error("differential channels not converting together");

  // channel one obeys the same ready gate as channel zero
  a_ch1_needs_ready: assert property ( // see R9
    s.ch[1].start |-> $past(s.ch[1].ready))
    else $error("channel one started while not ready");

  // channel one pipeline slot, also in differential mode
  a_ch1_spacing: assert property ( // see R14
    s.ch[1].start |=> !s.ch[1].start [*8])
    else $error("channel one restarted inside its pipeline slot");

  // every launch reloads the pipeline spacing counter
  a_start_loads_pipe: assert property ( // see R14
    s.ch[0].start |-> s.ch[0].pipe_cnt == PIPE_TICKS)
    else $error("launch did not reload the pipeline counter");

  // every launch opens a fresh conversion count
  a_start_opens_conv: assert property ( // see R12
    s.ch[0].start |-> s.ch[0].busy && s.ch[0].conv_cnt == 5'h00)
    else $error("launch did not restart the conversion count");

  // differential code is the signed sample moved to offset binary
  a_differential_bit_code_flip: assert property ( // see R20
    s.ch[0].start && $past(s.differential_bit) |-> s.ch[0].code == (s.ch[0].data ^ SIGN_FLIP))
    else $error("differential code not offset from signed data");

  // single ended code is the data register value itself
  a_single_code: assert property ( // see R11
    s.ch[0].start && !$past(s.differential_bit) |-> s.ch[0].code == s.ch[0].data)
    else $error("single ended code differs from data");

  // a controller disabled for two cycles running never reports a ready channel
  a_off_not_ready: assert property ( // see R8
    !s.enable && !$past(s.enable) |-> !s.ch[0].ready && !s.ch[1].ready)
    else $error("channel ready while controller disabled");

  // soft reset returns the reference choice to internal
  a_srst_ref_internal: assert property ( // see R10
    REQ.wr && REQ.addr == OFS_CTRL_A && REQ.wdata[SRST_BIT]
    |=> s.reference_select_field == REF_INTERNAL && !s.ch[0].ready)
    else $error("soft reset left reference or ready behind");

  // standby without standby run halts channel zero
  a_standby_halts: assert property ( // see R6
    stby && !s.cfg[0][STBY_BIT] |=> !s.ch[0].ready)
    else $error("channel zero kept running in standby");
endmodule

// ==== verif/ddc_core_model.sv ====
// Purpose: far side model: conversion and slow clocks, launch recorder
// Assumes: both clocks run free and are unrelated in phase to CLOCK
// Notes: no analog behaviour, only launch count, codes and launch spacing
`timescale 1ns/10ps
module ddc_core_model
  import ddc_pkg::*;
#(
  parameter int CONV_HALF = 10,
  parameter int SLOW_HALF = 100
) (
  output logic CONV_CLK,
  output logic SLOW_CLK,
  input wire ddc_core_t CORE,
  input wire logic CLOCK,
  output int n_launch,
  output logic [11:0] code0_seen,
  output logic [11:0] code1_seen,
  output int gap_ns
);
  time t_last;
  // conversion clock, offset from the system clock edges
  initial begin
    CONV_CLK = 1'b0;
    #3.3;
    forever #(CONV_HALF) CONV_CLK = ~CONV_CLK;
  end
  // slow refresh clock
  initial begin
    SLOW_CLK = 1'b0;
    #7.1;
    forever #(SLOW_HALF) SLOW_CLK = ~SLOW_CLK;
  end
  // record each channel zero launch and the time since the last one
  initial begin
    n_launch = 0;
    gap_ns = 0;
    t_last = 0;
    code0_seen = 12'h000;
    code1_seen = 12'h000;
  end
  always @(posedge CLOCK) begin
    if (CORE.start[0] === 1'b1) begin
      n_launch <= n_launch + 1;
      code0_seen <= CORE.code0;
      code1_seen <= CORE.code1;
      gap_ns <= int'($time - t_last);
      t_last <= $time;
    end
  end
endmodule

// ==== verif/tb_ddc_top.sv ====
// Purpose: register level test of the dual channel converter control
// Assumes: model supplies the conversion and slow clocks
// Notes: startup shortened to two conversion edges
`timescale 1ns/10ps
module tb_ddc_top
  import ddc_pkg::*;
;
  logic CLOCK, RST_N, STANDBY, conv_clk, slow_clk;
  logic [1:0] START_EV;
  ddc_req_t req;
  logic [31:0] RDATA, d;
  ddc_core_t core;
  logic [11:0] c0, c1;
  int n_launch, gap_ns, n_mismatch, tests_run, base;
  ddc_top #(.STARTUP_TICKS(8'h02)) u_ddc_top (.CLOCK(CLOCK), .RST_N(RST_N), .REQ(req),
    .RDATA(RDATA), .CONV_CLK(conv_clk), .SLOW_CLK(slow_clk), .START_EV(START_EV),
    .STANDBY(STANDBY), .CORE(core));
  ddc_core_model u_ddc_core_model (.CONV_CLK(conv_clk), .SLOW_CLK(slow_clk), .CORE(core),
    .CLOCK(CLOCK), .n_launch(n_launch), .code0_seen(c0), .code1_seen(c1), .gap_ns(gap_ns));
  // compare and count
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge CLOCK);
    req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge CLOCK);
    req.wr <= 1'b0;
  endtask
  // one cycle read strobe, data taken in the following cycle
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge CLOCK);
    req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge CLOCK);
    req.rd <= 1'b0;
    #1 v = RDATA;
  endtask
  task automatic rc(input string w, input logic [7:0] a, input logic [31:0] e);
    rd(a, d);
    check(w, d, e);
  endtask
  // poll status until the masked bits match, bounded
  task automatic wait_status(input logic [31:0] m, input logic [31:0] v);
    int k;
    k = 0;
    rd(OFS_STATUS, d);
    while ((d & m) !== v && k < 400) begin
      rd(OFS_STATUS, d);
      k++;
    end
    check("status", d & m, v);
  endtask
  // wait for a launch count, bounded
  task automatic wait_launch(input int n);
    int k;
    k = 0;
    while (n_launch < n && k < 2000) begin
      @(posedge CLOCK);
      k++;
    end
    #1;
    check("launches", n_launch, n);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // system clock
  initial begin
    CLOCK = 1'b0;
    forever #2 CLOCK = ~CLOCK;
  end
  // watchdog
  initial begin
    #100000;
    n_mismatch++;
    report_and_stop();
  end
  // main sequence
  initial begin
    n_mismatch = 0;
    tests_run = 0;
    RST_N = 1'b0;
    STANDBY = 1'b0;
    START_EV = 2'h0;
    req = '0;
    repeat (16) @(posedge CLOCK);
    RST_N <= 1'b1;
    rc("ctrl_a", OFS_CTRL_A, 32'h0);
    check("reference_select_field", core.reference_select_field, REF_INTERNAL);
    // channel zero: enable, dither, current 2; external reference; start event on
    wr(OFS_CHCTL0, 32'h25);
    wr(OFS_CHCTL1, 32'h0);
    wr(OFS_CTRL_B, 32'h4);
    wr(OFS_EVCTRL, 32'h1);
    wr(OFS_BUF0, 32'haa);
    rc("chctl0", OFS_CHCTL0, 32'h25);
    wr(OFS_CTRL_A, 32'h2);
    wr(OFS_DATA0, 32'h111);
    rc("ctrl_a on", OFS_CTRL_A, 32'h2);
    wait_status(32'h1, 32'h1);
    check("discarded", n_launch, 0);
    check("on", core.on, 2'h1);
    check("dither", core.dither, 2'h1);
    check("current", core.cur0, 2'h2);
    check("ref ext", core.reference_select_field, REF_EXTERNAL);
    wr(OFS_CTRL_B, 32'h0);
    rc("ctrl_b kept", OFS_CTRL_B, 32'h4);
    // back to back data writes, the second paced by the pipeline
    wr(OFS_DATA0, 32'h123);
    wr(OFS_DATA0, 32'h456);
    wait_launch(1);
    check("code first", c0, 12'h123);
    wait_launch(2);
    check("code second", c0, 12'h456);
    check("gap", 32'(gap_ns >= 220), 32'h1);
    rc("not done yet", OFS_STATUS, 32'h1);
    wait_status(32'h100, 32'h100);
    // start event moves the buffer into data
    @(posedge CLOCK) START_EV <= 2'h1;
    wait_launch(3);
    check("buffer copy", c0, 12'h0aa);
    rc("data from buffer", OFS_DATA0, 32'haa);
    @(posedge CLOCK) START_EV <= 2'h0;
    // standby without standby run halts the channel
    @(posedge CLOCK) STANDBY <= 1'b1;
    wait_status(32'h1, 32'h0);
    @(posedge CLOCK) STANDBY <= 1'b0;
    wait_status(32'h1, 32'h1);
    // differential, left aligned, refresh 3
    wr(OFS_CTRL_A, 32'h0);
    wr(OFS_CHCTL0, 32'h323);
    wr(OFS_CTRL_B, 32'h1);
    wr(OFS_CTRL_A, 32'h2);
    wait_status(32'h1, 32'h1);
    base = n_launch;
    wr(OFS_DATA0, 32'hffe00000);
    wait_launch(base + 1);
    check("differential_bit pos", c0, 12'h7fe);
    check("differential_bit neg", c1, 12'h801);
    check("differential_bit flag", core.differential_bit, 1'h1);
    check("cur1 mirror", core.cur1, 2'h2);
    wait_launch(base + 2);
    check("refresh code", c0, 12'h7fe);
    check("refresh gap", 32'(gap_ns >= 400 && gap_ns <= 620), 32'h1);
    // standby run keeps refresh going in standby
    wr(OFS_CTRL_A, 32'h0);
    wr(OFS_CHCTL0, 32'h32b);
    wr(OFS_CTRL_A, 32'h2);
    wait_status(32'h1, 32'h1);
    @(posedge CLOCK) STANDBY <= 1'b1;
    base = n_launch;
    wait_launch(base + 1);
    check("stby refresh code", c0, 12'h7fe);
    @(posedge CLOCK) STANDBY <= 1'b0;
    // soft reset clears everything
    wr(OFS_CTRL_A, 32'h1);
    rc("ctrl_b reset", OFS_CTRL_B, 32'h0);
    rc("chctl0 reset", OFS_CHCTL0, 32'h0);
    rc("ctrl_a reset", OFS_CTRL_A, 32'h0);
    rc("unmapped", 8'h40, 32'h0);
    report_and_stop();
  end
endmodule
